// >>> hw/dacsc_pkg.sv
// Shared constants and types for the converter control block
package dacsc_pkg;
	localparam int          DACSC_NREGS          = 32;
	localparam logic [4:0]  DACSC_ADDR_SETUP     = 5'h00;
	localparam logic [4:0]  DACSC_ADDR_I_OFS     = 5'h08;
	localparam logic [4:0]  DACSC_ADDR_Q_OFS     = 5'h0c;
	localparam logic [4:0]  DACSC_ADDR_REF_MODE  = 5'h0d;
	localparam logic [7:0]  DACSC_REG_DEFAULT    = 8'h00;
	localparam int          DACSC_BIT_BIDIR      = 7;
	localparam int          DACSC_BIT_LSB_FIRST  = 6;
	localparam int          DACSC_BIT_SOFT_RESET = 5;
	localparam int          DACSC_MULT_MSB       = 4;
	localparam int          DACSC_MULT_LSB       = 2;
	localparam int          DACSC_BIT_LOCK       = 1;
	localparam int          DACSC_BIT_OFS_STEER  = 7;
	localparam int          DACSC_BIT_REF_SINGLE = 0;
	localparam int          DACSC_INSTR_RW       = 7;
	localparam int          DACSC_INSTR_N_MSB    = 6;
	localparam int          DACSC_INSTR_N_LSB    = 5;
	localparam logic [3:0]  DACSC_RECOVER_MID    = 4'h9;
	localparam logic [7:0]  DACSC_SETTLE_MCLK    = 8'hc8;
	localparam int          DACSC_CODE_BITS      = 14;
	localparam int          DACSC_TOP_BITS       = 5;
	localparam int          DACSC_MID_BITS       = 4;
	localparam int          DACSC_LOW_BITS       = 5;
	localparam int          DACSC_TOP_ELEMS      = 31;
	localparam int          DACSC_MID_ELEMS      = 15;
	localparam int          DACSC_ELEMS          = 51;

	typedef enum logic [1:0] {
		DACSC_INSTR,
		DACSC_DATA,
		DACSC_DONE
	} dacsc_phase_t;
endpackage

// >>> hw/dacsc_seg_decode.sv
// Segmented current-source steering decoder for one converter channel
`timescale 1ns/1ps
module dacsc_seg_decode
	import dacsc_pkg::*;
#(
	parameter int TOP_BITS = DACSC_TOP_BITS,
	parameter int MID_BITS = DACSC_MID_BITS,
	parameter int LOW_BITS = DACSC_LOW_BITS
) (
	input  wire logic                                  clock_i,
	input  wire logic                                  rst_n_i,
	input  wire logic [TOP_BITS+MID_BITS+LOW_BITS-1:0] code_i,
	output logic      [(2**TOP_BITS)+(2**MID_BITS)+LOW_BITS-3:0] steer_o
);
	localparam int NTOP = (2**TOP_BITS) - 1;
	localparam int NMID = (2**MID_BITS) - 1;
	localparam int NALL = NTOP + NMID + LOW_BITS;

	logic [TOP_BITS-1:0] top_s;
	logic [MID_BITS-1:0] mid_s;
	logic [NALL-1:0]     steer_nxt;

	assign top_s = code_i[TOP_BITS+MID_BITS+LOW_BITS-1:MID_BITS+LOW_BITS];
	assign mid_s = code_i[MID_BITS+LOW_BITS-1:LOW_BITS];

	// High: element to primary output, low: to complementary output
	for (genvar k = 0; k < NTOP; k++) begin : g_top
		assign steer_nxt[LOW_BITS+NMID+k] = (int'(top_s) > k);
	end
	for (genvar k = 0; k < NMID; k++) begin : g_mid
		assign steer_nxt[LOW_BITS+k] = (int'(mid_s) > k);
	end
	assign steer_nxt[LOW_BITS-1:0] = code_i[LOW_BITS-1:0];

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			steer_o <= '0;
		end else begin
			steer_o <= steer_nxt;
		end
	end
endmodule

// >>> hw/dacsc_top.sv
// Serial register port, setup register, offset steering and channel decoders
//
// Behaviour
// - Port setup held in setup register bits 7,6
// - New setup applies from next bit onward
// - Soft reset acts at byte end, mid-transfer
// - Soft reset defaults all but setup register
// - Mirrored pattern write restores setup, resets
// - Second write with reset low sets multiplier
// - Clock stable within 200 master cycles
// - Offset current to exactly one output
// - Bit 7 of offset registers steers offset
// - First offset in-phase, second quadrature
// - Code split 5-4-5: 31, 15, binary
// - Each element steered by input code
// - Single-resistor mode halves full-scale current
// - Setup bit 7 selects bidirectional data pin
// - Bit 6 selects LSB-first, default MSB-first
// - Select high aborts, partial byte dropped
`timescale 1ns/1ps
module dacsc_top
	import dacsc_pkg::*;
(
	input  wire logic                       clock_i,
	input  wire logic                       rst_n_i,
	input  wire logic                       spi_sclk_i,
	input  wire logic                       port_select_low_n_i,
	input  wire logic                       sdio_i,
	output logic                            sdio_o,
	output logic                            sdio_oe_o,
	output logic                            serial_data_out_pin_o,
	output logic                            serial_data_out_pin_oe_o,
	input  wire logic [DACSC_CODE_BITS-1:0] in_phase_code_i,
	input  wire logic [DACSC_CODE_BITS-1:0] quadrature_code_i,
	output logic      [DACSC_ELEMS-1:0]     in_phase_converter_steer_o,
	output logic      [DACSC_ELEMS-1:0]     quadrature_converter_steer_o,
	output logic                            in_phase_offset_primary_o,
	output logic                            in_phase_offset_comp_o,
	output logic                            quadrature_offset_primary_o,
	output logic                            quadrature_offset_comp_o,
	output logic                            single_resistor_mode_o,
	output logic [2:0]                      multiplier_setting_o,
	output logic                            system_clock_stable_o
);
	logic [2:0]         sclk_sync_r;
	logic [1:0]         csb_sync_r;
	logic [1:0]         sdi_sync_r;
	logic               sclk_rise;
	logic               sclk_fall;
	logic               csb_s;
	logic               sdi_s;

	dacsc_phase_t       phase_r,  phase_nxt;
	logic [2:0]         bitcnt_r, bitcnt_nxt;
	logic [7:0]         shift_r,  shift_nxt;
	logic [4:0]         addr_r,   addr_nxt;
	logic [1:0]         left_r,   left_nxt;
	logic               rw_r,     rw_nxt;
	logic [7:0]         tx_r,     tx_nxt;
	logic               dout_r,   dout_nxt;
	logic               sdio_oe_r, sdio_oe_nxt;
	logic               sdo_oe_r,  sdo_oe_nxt;
	logic [7:0]         regs_r   [DACSC_NREGS];
	logic [7:0]         regs_nxt [DACSC_NREGS];
	logic [7:0]         settle_r, settle_nxt;
	logic               stable_r, stable_nxt;
	logic               i_prim_r;
	logic               q_prim_r;

	logic [7:0]         byte_v;
	logic               byte_done;
	logic               wr_en;
	logic               recover_v;
	logic               mult_chg;
	logic               lsb_new;
	logic [4:0]         addr_next_v;

	// Synchronisers; select and data feed logic from their last stage, the clock from its last two stages
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_sync_r <= '0;
			csb_sync_r  <= 2'h3;
			sdi_sync_r  <= '0;
		end else begin
			sclk_sync_r <= {sclk_sync_r[1:0], spi_sclk_i};
			csb_sync_r  <= {csb_sync_r[0], port_select_low_n_i};
			sdi_sync_r  <= {sdi_sync_r[0], sdio_i};
		end
	end

	assign sclk_rise = sclk_sync_r[1] & ~sclk_sync_r[2];
	assign sclk_fall = ~sclk_sync_r[1] & sclk_sync_r[2];
	assign csb_s     = csb_sync_r[1];
	assign sdi_s     = sdi_sync_r[1];

	function automatic logic [7:0] read_value(input logic [4:0] a, input logic [7:0] r0,
			input logic [7:0] ra, input logic stb);
		logic [7:0] v;
		v = (a == DACSC_ADDR_SETUP) ? r0 : ra;
		if (a == DACSC_ADDR_SETUP) begin
			v[DACSC_BIT_LOCK] = stb;
		end
		return v;
	endfunction

	// Serial engine and register file
	always_comb begin
		phase_nxt   = phase_r;
		bitcnt_nxt  = bitcnt_r;
		shift_nxt   = shift_r;
		addr_nxt    = addr_r;
		left_nxt    = left_r;
		rw_nxt      = rw_r;
		tx_nxt      = tx_r;
		dout_nxt    = dout_r;
		regs_nxt    = regs_r;
		wr_en       = 1'b0;
		recover_v   = 1'b0;
		mult_chg    = 1'b0;
		lsb_new     = regs_r[DACSC_ADDR_SETUP][DACSC_BIT_LSB_FIRST];
		addr_next_v = addr_r;
		if (regs_r[DACSC_ADDR_SETUP][DACSC_BIT_LSB_FIRST]) begin
			byte_v = {sdi_s, shift_r[7:1]};
		end else begin
			byte_v = {shift_r[6:0], sdi_s};
		end
		byte_done = sclk_rise && !csb_s && (bitcnt_r == 3'h7);

		if (csb_s) begin
			phase_nxt  = DACSC_INSTR;
			bitcnt_nxt = 3'h0;
		end else if (sclk_rise && phase_r != DACSC_DONE) begin
			shift_nxt  = byte_v;
			bitcnt_nxt = bitcnt_r + 3'h1;
			if (byte_done && phase_r == DACSC_INSTR) begin
				rw_nxt    = byte_v[DACSC_INSTR_RW];
				left_nxt  = byte_v[DACSC_INSTR_N_MSB:DACSC_INSTR_N_LSB];
				addr_nxt  = byte_v[4:0];
				phase_nxt = DACSC_DATA;
				tx_nxt    = read_value(byte_v[4:0], regs_r[0], regs_r[byte_v[4:0]], stable_r);
			end else if (byte_done) begin
				wr_en     = !rw_r;
				recover_v = (byte_v[7] == byte_v[0]) && (byte_v[6] == byte_v[1]) &&
					(byte_v[5:2] == DACSC_RECOVER_MID);
				if (wr_en && addr_r == DACSC_ADDR_SETUP) begin
					if (recover_v || byte_v[DACSC_BIT_SOFT_RESET]) begin
						for (int i = 1; i < DACSC_NREGS; i++) begin
							regs_nxt[i] = DACSC_REG_DEFAULT;
						end
						regs_nxt[0][DACSC_BIT_BIDIR]     = byte_v[DACSC_BIT_BIDIR];
						regs_nxt[0][DACSC_BIT_LSB_FIRST] = byte_v[DACSC_BIT_LSB_FIRST];
					end else begin
						regs_nxt[0] = byte_v;
						regs_nxt[0][DACSC_BIT_LOCK] = 1'b0;
						mult_chg = (byte_v[DACSC_MULT_MSB:DACSC_MULT_LSB] !=
							regs_r[0][DACSC_MULT_MSB:DACSC_MULT_LSB]);
					end
					lsb_new = byte_v[DACSC_BIT_LSB_FIRST];
				end else if (wr_en) begin
					regs_nxt[addr_r] = byte_v;
				end
				addr_next_v = lsb_new ? addr_r + 5'h01 : addr_r - 5'h01;
				if (left_r == 2'h0) begin
					phase_nxt = DACSC_DONE;
				end else begin
					left_nxt = left_r - 2'h1;
					addr_nxt = addr_next_v;
					tx_nxt   = read_value(addr_next_v, regs_nxt[0], regs_nxt[addr_next_v],
						stable_r);
				end
			end
		end else if (sclk_fall && phase_r == DACSC_DATA && rw_r) begin
			if (regs_r[DACSC_ADDR_SETUP][DACSC_BIT_LSB_FIRST]) begin
				dout_nxt = tx_r[bitcnt_r];
			end else begin
				dout_nxt = tx_r[3'h7 - bitcnt_r];
			end
		end
		sdio_oe_nxt = !csb_s && phase_nxt == DACSC_DATA && rw_nxt &&
			regs_nxt[0][DACSC_BIT_BIDIR];
		sdo_oe_nxt  = !csb_s && phase_nxt == DACSC_DATA && rw_nxt &&
			!regs_nxt[0][DACSC_BIT_BIDIR];
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_r   <= DACSC_INSTR;
			bitcnt_r  <= '0;
			shift_r   <= '0;
			addr_r    <= '0;
			left_r    <= '0;
			rw_r      <= 1'b0;
			tx_r      <= '0;
			dout_r    <= 1'b0;
			sdio_oe_r <= 1'b0;
			sdo_oe_r  <= 1'b0;
			for (int i = 0; i < DACSC_NREGS; i++) begin
				regs_r[i] <= DACSC_REG_DEFAULT;
			end
		end else begin
			phase_r   <= phase_nxt;
			bitcnt_r  <= bitcnt_nxt;
			shift_r   <= shift_nxt;
			addr_r    <= addr_nxt;
			left_r    <= left_nxt;
			rw_r      <= rw_nxt;
			tx_r      <= tx_nxt;
			dout_r    <= dout_nxt;
			sdio_oe_r <= sdio_oe_nxt;
			sdo_oe_r  <= sdo_oe_nxt;
			regs_r    <= regs_nxt;
		end
	end

	// Frequency settling after a multiplier change
	always_comb begin
		if (mult_chg) begin
			settle_nxt = DACSC_SETTLE_MCLK - 8'h01;
		end else if (settle_r != 8'h00) begin
			settle_nxt = settle_r - 8'h01;
		end else begin
			settle_nxt = 8'h00;
		end
		stable_nxt = (settle_nxt == 8'h00);
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			settle_r <= '0;
			stable_r <= 1'b1;
		end else begin
			settle_r <= settle_nxt;
			stable_r <= stable_nxt;
		end
	end

	// Primary-side offset flags kept in flops of their own
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			i_prim_r <= 1'b1;
			q_prim_r <= 1'b1;
		end else begin
			i_prim_r <= ~regs_nxt[DACSC_ADDR_I_OFS][DACSC_BIT_OFS_STEER];
			q_prim_r <= ~regs_nxt[DACSC_ADDR_Q_OFS][DACSC_BIT_OFS_STEER];
		end
	end

	assign sdio_o                   = dout_r;
	assign sdio_oe_o                = sdio_oe_r;
	assign serial_data_out_pin_o    = dout_r;
	assign serial_data_out_pin_oe_o = sdo_oe_r;
	assign in_phase_offset_comp_o      = regs_r[DACSC_ADDR_I_OFS][DACSC_BIT_OFS_STEER];
	assign in_phase_offset_primary_o   = i_prim_r;
	assign quadrature_offset_comp_o    = regs_r[DACSC_ADDR_Q_OFS][DACSC_BIT_OFS_STEER];
	assign quadrature_offset_primary_o = q_prim_r;
	// Set: shared reference split over both channels, half full-scale
	assign single_resistor_mode_o = regs_r[DACSC_ADDR_REF_MODE][DACSC_BIT_REF_SINGLE];
	assign multiplier_setting_o   = regs_r[DACSC_ADDR_SETUP][DACSC_MULT_MSB:DACSC_MULT_LSB];
	assign system_clock_stable_o  = stable_r;

	dacsc_seg_decode u_in_phase (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.code_i  (in_phase_code_i),
		.steer_o (in_phase_converter_steer_o)
	);

	dacsc_seg_decode u_quadrature (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.code_i  (quadrature_code_i),
		.steer_o (quadrature_converter_steer_o)
	);

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	a_ofs_one_side: assert property (in_phase_offset_primary_o != in_phase_offset_comp_o &&
		quadrature_offset_primary_o != quadrature_offset_comp_o)
		else $error("offset current on both or neither output");
	a_ofs_i_steer: assert property (wr_en && addr_r == DACSC_ADDR_I_OFS
		|=> in_phase_offset_comp_o == $past(byte_v[7]))
		else $error("in-phase offset steering not from written bit 7");
	a_ofs_q_steer: assert property (wr_en && addr_r == DACSC_ADDR_Q_OFS
		|=> quadrature_offset_comp_o == $past(byte_v[7]) && $stable(in_phase_offset_comp_o))
		else $error("quadrature offset steering wrong");
	a_cfg_applies_now: assert property (wr_en && addr_r == DACSC_ADDR_SETUP
		|=> regs_r[0][7:6] == $past(byte_v[7:6]))
		else $error("port setup not taken at end of byte");
	a_soft_reset_clr: assert property (wr_en && addr_r == DACSC_ADDR_SETUP &&
		byte_v[DACSC_BIT_SOFT_RESET] |=> regs_r[8] == DACSC_REG_DEFAULT &&
		regs_r[12] == DACSC_REG_DEFAULT && regs_r[13] == DACSC_REG_DEFAULT)
		else $error("soft reset left a register changed");
	a_recover_keeps_mult: assert property (wr_en && addr_r == DACSC_ADDR_SETUP && recover_v
		|=> $stable(multiplier_setting_o) && regs_r[8] == DACSC_REG_DEFAULT)
		else $error("recovery write misbehaved");
	a_select_abort: assert property (csb_s |=> phase_r == DACSC_INSTR && bitcnt_r == 3'h0 &&
		!sdio_oe_o && !serial_data_out_pin_oe_o)
		else $error("select high did not abort the transfer");
	a_settle_start: assert property (mult_chg |=> !system_clock_stable_o)
		else $error("clock reported stable right after multiplier change");
	a_settle_bound: assert property (mult_chg ##1 !mult_chg [*8]
		|-> settle_r == DACSC_SETTLE_MCLK - 8'h08)
		else $error("settle counter not running");
	a_settle_end: assert property (settle_r == 8'h01 && !mult_chg |=> system_clock_stable_o)
		else $error("clock not stable at end of settling");
	a_pin_mode: assert property (sdio_oe_o |-> regs_r[0][DACSC_BIT_BIDIR] &&
		!serial_data_out_pin_oe_o)
		else $error("data driven on the wrong pin");

	c_recover_write: cover property (wr_en && addr_r == DACSC_ADDR_SETUP && recover_v);
	c_read_byte: cover property (byte_done && phase_r == DACSC_DATA && rw_r);
	c_multibyte: cover property (wr_en && left_r != 2'h0);
	c_settle_done: cover property (settle_r == 8'h01 ##1 system_clock_stable_o);
endmodule

// >>> dv/dacsc_host_model.sv
// Host controller model driving the serial register port
`timescale 1ns/1ps
module dacsc_host_model (
	input  wire logic clock_i,
	input  wire logic din_i,
	output logic      sclk_o,
	output logic      sel_n_o,
	output logic      sdo_o
);
	logic [7:0] wbuf [4];
	logic [7:0] rbuf [4];
	logic       lsb_first = 1'b0;
	initial begin
		sclk_o = 1'b0;
		sel_n_o = 1'b1;
		sdo_o = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	// Launch while low, sample read bit at the edge that raises the clock
	task automatic shift_byte(input logic [7:0] b, input int nbits, output logic [7:0] r);
		int k;
		r = 8'h00;
		for (int i = 0; i < nbits; i++) begin
			k = lsb_first ? i : 7 - i;
			sclk_o <= 1'b0;
			sdo_o <= b[k];
			wait_clk(4);
			r[k] = din_i;
			sclk_o <= 1'b1;
			wait_clk(4);
		end
	endtask
	// Whole frame; cut limits the bits shifted before select is dropped
	task automatic frame(input logic rw, input int nbytes, input logic [4:0] addr, input int cut);
		logic [7:0] r;
		logic [4:0] a;
		int         left;
		a = addr;
		left = cut;
		sel_n_o <= 1'b0;
		wait_clk(4);
		shift_byte({rw, 2'(nbytes - 1), addr}, (left < 8) ? left : 8, r);
		left -= 8;
		for (int j = 0; j < nbytes && left > 0; j++) begin
			shift_byte(wbuf[j], (left < 8) ? left : 8, r);
			left -= 8;
			rbuf[j] = r;
			if (!rw && a == 5'h00) lsb_first = wbuf[j][6];
			a = lsb_first ? a + 5'h01 : a - 5'h01;
		end
		sclk_o <= 1'b0;
		sdo_o <= ~sdo_o;
		wait_clk(4);
		sel_n_o <= 1'b1;
		wait_clk(8);
	endtask
endmodule

// >>> dv/dac_serial_config_and_output_control_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module dac_serial_config_and_output_control_bench;
	import dacsc_pkg::*;
	logic                       clock_i = 1'b0;
	logic                       rst_n_i = 1'b0;
	logic                       sclk, sel_n, hsdo, sdi, serial_data_out_pin, sdo_en, dout, dout_en, hdin;
	logic [DACSC_CODE_BITS-1:0] icode = '0;
	logic [DACSC_CODE_BITS-1:0] qcode = '0;
	logic [DACSC_ELEMS-1:0]     isteer, qsteer;
	logic                       ip, ic, qp, qc, one_r, stable;
	logic                       bidir_seen = 1'b0;
	logic [2:0]                 mult;
	logic [7:0]                 mdl [32];
	int                         num_errors = 0;
	int                         check_count = 0;
	int                         low_cnt = 0;
	always #20 clock_i = ~clock_i;
	always @(posedge clock_i) if (!stable) low_cnt <= low_cnt + 1;
	always @(posedge clock_i) if (sdo_en === 1'b1) bidir_seen <= 1'b1;
	assign sdi = sdo_en ? serial_data_out_pin : hsdo;
	// Host sees the driven pin; an undriven line reads back inverted
	assign hdin = sdo_en ? serial_data_out_pin : dout_en ? dout : ~dout;
	dacsc_top u_dacsc_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .spi_sclk_i(sclk),
		.port_select_low_n_i(sel_n), .sdio_i(sdi), .sdio_o(serial_data_out_pin), .sdio_oe_o(sdo_en),
		.serial_data_out_pin_o(dout), .serial_data_out_pin_oe_o(dout_en),
		.in_phase_code_i(icode), .quadrature_code_i(qcode),
		.in_phase_converter_steer_o(isteer), .quadrature_converter_steer_o(qsteer),
		.in_phase_offset_primary_o(ip), .in_phase_offset_comp_o(ic),
		.quadrature_offset_primary_o(qp), .quadrature_offset_comp_o(qc),
		.single_resistor_mode_o(one_r), .multiplier_setting_o(mult),
		.system_clock_stable_o(stable));
	dacsc_host_model u_dacsc_host_model (.clock_i(clock_i), .din_i(hdin), .sclk_o(sclk),
		.sel_n_o(sel_n), .sdo_o(hsdo));
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	function automatic logic [63:0] steer_of(input logic [13:0] c);
		logic [63:0] s;
		s = 64'(c[4:0]);
		for (int k = 0; k < 15; k++) s[5 + k] = (c[8:5] > k);
		for (int k = 0; k < 31; k++) s[20 + k] = (c[13:9] > k);
		return s;
	endfunction
	task automatic outs();
		check("i_comp", ic, mdl[8][7]);
		check("i_prim", ip, !mdl[8][7]);
		check("q_comp", qc, mdl[12][7]);
		check("q_prim", qp, !mdl[12][7]);
		check("one_r", one_r, mdl[13][0]);
		check("mult", mult, mdl[0][4:2]);
	endtask
	// Frame plus model update, address stepping in the order in force
	task automatic wr(input logic [4:0] addr, input int n);
		logic [4:0] a;
		logic [7:0] d;
		a = addr;
		u_dacsc_host_model.frame(1'b0, n, addr, 99);
		for (int j = 0; j < n; j++) begin
			d = u_dacsc_host_model.wbuf[j];
			if (a == 5'h00 && d[5]) begin
				for (int k = 1; k < 32; k++) mdl[k] = 8'h00;
				mdl[0][7:6] = d[7:6];
			end else if (a == 5'h00) mdl[0] = d & 8'hdd;
			else mdl[a] = d;
			a = mdl[0][6] ? a + 5'h01 : a - 5'h01;
		end
	endtask
	task automatic rd(input logic [4:0] addr, input logic [7:0] exp);
		u_dacsc_host_model.frame(1'b1, 1, addr, 99);
		check("read", u_dacsc_host_model.rbuf[0], exp);
	endtask
	task automatic settle();
		logic [2:0] m;
		m = mdl[0][4:2] + 3'd1 + 3'($urandom % 7);
		u_dacsc_host_model.wbuf[0] = {mdl[0][7:6], 1'b0, m, 2'b00};
		low_cnt = 0;
		wr(5'h00, 1);
		repeat (220) @(posedge clock_i);
		check("settle", low_cnt inside {[190:200]}, 1'b1);
		outs();
	endtask
	initial begin
		fork
			begin
				#2000000;
				num_errors++;
				conclude();
			end
		join_none
		void'($urandom(32'h53e15711));
		for (int k = 0; k < 32; k++) mdl[k] = 8'h00;
		repeat (2) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		check("stable", stable, 1'b1);
		outs();
		$display("test reset done");
		for (int t = 0; t < 4; t++) begin
			u_dacsc_host_model.wbuf[0] = 8'($urandom);
			u_dacsc_host_model.wbuf[1] = 8'($urandom);
			wr(5'h0d, 2);
			u_dacsc_host_model.wbuf[0] = 8'($urandom);
			wr(5'h08, 1);
			outs();
			rd(5'h08, mdl[8]);
			rd(5'h0c, mdl[12]);
		end
		$display("test offsets done");
		for (int t = 0; t < 10; t++) begin
			@(posedge clock_i);
			icode <= (t == 0) ? '0 : (t == 1) ? '1 : 14'($urandom);
			qcode <= 14'($urandom);
			@(posedge clock_i);
			@(negedge clock_i);
			check("isteer", isteer, steer_of(icode));
			check("qsteer", qsteer, steer_of(qcode));
		end
		$display("test decoder done");
		u_dacsc_host_model.wbuf[0] = 8'h80;
		wr(5'h08, 1);
		u_dacsc_host_model.wbuf[0] = 8'h5a;
		u_dacsc_host_model.wbuf[1] = 8'h60;
		u_dacsc_host_model.wbuf[2] = 8'($urandom);
		wr(5'h01, 3);
		outs();
		rd(5'h01, mdl[1]);
		u_dacsc_host_model.wbuf[0] = 8'h80;
		wr(5'h0c, 1);
		outs();
		$display("test midframe done");
		u_dacsc_host_model.wbuf[0] = 8'h24;
		wr(5'h00, 1);
		u_dacsc_host_model.wbuf[0] = 8'h80;
		wr(5'h08, 1);
		outs();
		settle();
		rd(5'h00, mdl[0] | 8'h02);
		$display("test recovery done");
		u_dacsc_host_model.wbuf[0] = ~mdl[8];
		u_dacsc_host_model.frame(1'b0, 1, 5'h08, 12);
		outs();
		check("bidir", bidir_seen, 1'b0);
		$display("test abort done");
		u_dacsc_host_model.wbuf[0] = {1'b1, mdl[0][6:0]};
		wr(5'h00, 1);
		rd(5'h08, mdl[8]);
		check("bidir", bidir_seen, 1'b1);
		outs();
		$display("test bidir done");
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		rst_n_i <= 1'b1;
		for (int k = 0; k < 32; k++) mdl[k] = 8'h00;
		repeat (4) @(posedge clock_i);
		check("stable", stable, 1'b1);
		outs();
		rd(5'h08, mdl[8]);
		$display("test reset again done");
		conclude();
	end
endmodule
